// ==== dv/breaker_command_control_asserts.sv ====
// Port assertions for the breaker command control block
`timescale 1ns/1ns
module breaker_command_control_asserts (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ms_tick,
  input wire logic cmd_valid,
  input wire logic cmd_close,
  input wire logic cmd_select,
  input wire logic cmd_skip_check,
  input wire logic feedback_open,
  input wire logic feedback_closed,
  input wire logic open_permit,
  input wire logic close_permit,
  input wire logic command_block,
  input wire logic external_switching,
  input wire logic open_pulse_out,
  input wire logic close_pulse_out,
  input wire logic operation_pulse,
  input wire logic unintended_operation,
  input wire logic breaker_opened,
  input wire logic breaker_intermediate,
  input wire logic accept_event,
  input wire logic reject_event,
  input wire logic status_event
);
  logic [10:0] plen_q;
  logic [10:0] olen_q;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Tick counts of pulses in progress
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      plen_q <= 11'h000;
      olen_q <= 11'h000;
    end else begin
      plen_q <= (open_pulse_out || close_pulse_out) ? plen_q + 11'(ms_tick) : 11'h000;
      olen_q <= operation_pulse ? olen_q + 11'(ms_tick) : 11'h000;
    end
  end
  property p_block;
    cmd_valid && command_block |=> !accept_event;
  endproperty
  a_block: assert property (p_block) else $error("accept while blocked");
  property p_open_permit;
    cmd_valid && !cmd_select && !cmd_close && !open_permit && !cmd_skip_check |=> !accept_event;
  endproperty
  a_open_permit: assert property (p_open_permit) else $error("open without permit");
  property p_close_permit;
    cmd_valid && !cmd_select && cmd_close && !close_permit && !cmd_skip_check |=> !accept_event;
  endproperty
  a_close_permit: assert property (p_close_permit) else $error("close without permit");
  property p_one_pulse;
    !(open_pulse_out && close_pulse_out);
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("both pulses high");
  property p_one_answer;
    !(accept_event && reject_event);
  endproperty
  a_one_answer: assert property (p_one_answer) else $error("accept and reject");
  property p_mid_cause;
    $rose(breaker_intermediate) |-> $past(feedback_open) == $past(feedback_closed);
  endproperty
  a_mid_cause: assert property (p_mid_cause) else $error("intermediate on valid");
  property p_opened;
    feedback_open && !feedback_closed ##1 feedback_open && !feedback_closed |-> breaker_opened;
  endproperty
  a_opened: assert property (p_opened) else $error("opened not shown");
  property p_op_len;
    $fell(operation_pulse) |-> olen_q == 11'h096;
  endproperty
  a_op_len: assert property (p_op_len) else $error("operation pulse length");
  property p_min_pulse;
    $fell(open_pulse_out || close_pulse_out) |-> plen_q >= 11'h064 && plen_q <= 11'h3e8;
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("command pulse length");
  property p_unint;
    $rose(unintended_operation) |-> !$past(external_switching) || !$past(external_switching, 2);
  endproperty
  a_unint: assert property (p_unint) else $error("unintended while external");
  property p_status_ev;
    feedback_open != feedback_closed && $past(feedback_open != feedback_closed)
      && $changed(feedback_closed) |=> status_event;
  endproperty
  a_status_ev: assert property (p_status_ev) else $error("no status event");
endmodule
bind breaker_command_control breaker_command_control_asserts u_asserts (.*);

// ==== dv/breaker_contacts.sv ====
// Behavioural breaker with auxiliary contacts and coil inputs
`timescale 1ns/1ns
module breaker_contacts #(
  parameter int TRAVEL = 20
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic open_pulse_out,
  input wire logic close_pulse_out,
  input wire logic stuck,
  input wire logic ext_trip,
  input wire logic hold_mid,
  output logic feedback_open,
  output logic feedback_closed
);
  logic closed_q;
  int travel_q;
  // Both contacts open while moving or held mid
  assign feedback_open = !hold_mid && travel_q == 0 && !closed_q;
  assign feedback_closed = !hold_mid && travel_q == 0 && closed_q;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      closed_q <= 1'h1;
      travel_q <= 0;
    end else if (ext_trip) begin
      closed_q <= !closed_q;
    end else if (!stuck && (closed_q ? open_pulse_out : close_pulse_out)) begin
      travel_q <= (travel_q == TRAVEL) ? 0 : travel_q + 1;
      if (travel_q == TRAVEL)
        closed_q <= !closed_q;
    end
  end
endmodule

// ==== dv/tb_top.sv ====
// Self-checking bench for the breaker command control block
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'h0;
  logic reset_n = 1'h0;
  logic ms_tick = 1'h1;
  logic slow = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_write = 1'h0, reg_read = 1'h0, cmd_valid = 1'h0, cmd_remote = 1'h0;
  logic cmd_close = 1'h0, cmd_select = 1'h0, cmd_skip_check = 1'h0, open_permit = 1'h1;
  logic close_permit = 1'h1, command_block = 1'h0, sync_state_ok = 1'h1;
  logic sync_switch_impulse = 1'h0, external_switching = 1'h0;
  logic stuck = 1'h0, ext_trip = 1'h0, hold_mid = 1'h0, acc, rej;
  logic [15:0] reg_rdata;
  logic feedback_open, feedback_closed, open_pulse_out, close_pulse_out, sync_switch_start;
  logic operation_pulse, unintended_operation, breaker_opened, breaker_closed;
  logic breaker_intermediate, invalid_position, accept_event, reject_event, status_event;
  logic [3:0] seen = 4'h0;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  breaker_command_control u_dut (.*);
  breaker_contacts u_breaker (.*);
  always #25 clock = ~clock;
  // Tick every cycle, or every other cycle when slow
  always @(posedge clock) ms_tick <= slow ? !ms_tick : 1'h1;
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'h1;
    @(posedge clock);
    reg_write <= 1'h0;
  endtask
  task automatic rd(string what, logic [3:0] a, logic [15:0] exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'h1;
    @(posedge clock);
    reg_read <= 1'h0;
    #1;
    chk(what, exp, reg_rdata);
  endtask
  task automatic cmd(logic rem, logic cls, logic sel);
    @(posedge clock);
    cmd_valid <= 1'h1;
    cmd_remote <= rem;
    cmd_close <= cls;
    cmd_select <= sel;
    @(posedge clock);
    cmd_valid <= 1'h0;
    #1;
    acc = accept_event;
    rej = reject_event;
  endtask
  task automatic step(int n);
    repeat (n) begin
      @(posedge clock);
      #1;
      seen = seen | {invalid_position, reject_event, sync_switch_start, accept_event};
    end
  endtask
  task automatic pulse_len(output int n);
    n = 0;
    while ((open_pulse_out || close_pulse_out) && n < 2000) begin
      step(1);
      n++;
    end
  endtask
  task automatic s_regs;
    logic [15:0] rst [7] = '{16'h0013, 16'h00c8, 16'h012c, 16'h0064, 16'h03e8, 16'h0000, 16'h1388};
    for (int i = 0; i < 7; i++) rd("config reset", 4'(i), rst[i]);
    rd("op count", 4'h8, 16'h0000);
    rd("unmapped", 4'h9, 16'h0000);
    wr(4'h7, 16'hffff);
    rd("status", 4'h7, 16'h0002);
  endtask
  task automatic s_open;
    int n;
    cmd(1'h0, 1'h0, 1'h0);
    chk("open accept", 1'h1, acc);
    chk("open pulse", 1'h1, open_pulse_out);
    pulse_len(n);
    chk("open early end", 1'h1, n >= 100 && n <= 101);
    step(5);
    chk("opened", 1'h1, breaker_opened);
    chk("operation pulse", 1'h1, operation_pulse);
    rd("op count", 4'h8, 16'h0001);
    step(200);
  endtask
  task automatic s_stuck;
    int n;
    wr(4'h0, 16'h0017);
    stuck <= 1'h1;
    seen = 4'h0;
    cmd(1'h1, 1'h1, 1'h0);
    chk("close pulse", 1'h1, close_pulse_out);
    pulse_len(n);
    chk("full pulse", 1'h1, n >= 300 && n <= 301);
    chk("invalid position", 1'h1, seen[3]);
    stuck <= 1'h0;
    wr(4'h0, 16'h0013);
  endtask
  task automatic s_reject;
    wr(4'h0, 16'h0012);
    cmd(1'h0, 1'h1, 1'h0);
    chk("local disabled", 2'h1, {acc, rej});
    wr(4'h0, 16'h0013);
    open_permit <= 1'h0;
    close_permit <= 1'h0;
    cmd(1'h1, 1'h0, 1'h0);
    chk("no open permit", 2'h1, {acc, rej});
    cmd_skip_check <= 1'h1;
    cmd(1'h1, 1'h1, 1'h0);
    chk("forced check", 2'h1, {acc, rej});
    cmd_skip_check <= 1'h0;
    cmd(1'h0, 1'h1, 1'h0);
    chk("no close permit", 2'h1, {acc, rej});
    open_permit <= 1'h1;
    close_permit <= 1'h1;
    command_block <= 1'h1;
    cmd(1'h1, 1'h0, 1'h0);
    chk("blocked", 2'h1, {acc, rej});
    command_block <= 1'h0;
  endtask
  task automatic s_sync;
    wr(4'h4, 16'h0014);
    sync_state_ok <= 1'h0;
    seen = 4'h0;
    cmd(1'h1, 1'h1, 1'h0);
    step(40);
    chk("sync expiry", 1'h1, seen[2]);
    chk("no sync start", 1'h0, seen[1]);
    wr(4'h5, 16'h001e);
    cmd(1'h1, 1'h1, 1'h0);
    step(25);
    chk("sync start", 1'h1, sync_switch_start);
    seen = 4'h0;
    step(40);
    chk("switch expiry", 2'h2, {seen[2], sync_switch_start});
    chk("no close", 1'h0, close_pulse_out);
    sync_state_ok <= 1'h1;
  endtask
  task automatic s_sbo;
    wr(4'h6, 16'h0032);
    wr(4'h0, 16'h001b);
    cmd(1'h1, 1'h1, 1'h0);
    chk("operate unselected", 2'h1, {acc, rej});
    cmd(1'h1, 1'h1, 1'h1);
    chk("select", 2'h2, {acc, rej});
    slow <= 1'h1;
    step(70);
    rd("still selected", 4'h7, 16'h0061);
    step(40);
    cmd(1'h1, 1'h1, 1'h0);
    chk("selection lapsed", 2'h1, {acc, rej});
    slow <= 1'h0;
    wr(4'h0, 16'h0013);
  endtask
  task automatic s_unint;
    external_switching <= 1'h1;
    ext_trip <= 1'h1;
    step(1);
    ext_trip <= 1'h0;
    step(5);
    chk("external change", 2'h1, {unintended_operation, breaker_closed});
    external_switching <= 1'h0;
    step(200);
    ext_trip <= 1'h1;
    step(1);
    ext_trip <= 1'h0;
    step(5);
    chk("unintended", 2'h3, {unintended_operation, breaker_opened});
    hold_mid <= 1'h1;
    step(90);
    chk("not yet mid", 1'h0, breaker_intermediate);
    step(20);
    chk("intermediate", 1'h1, breaker_intermediate);
    hold_mid <= 1'h0;
    step(200);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    reset_n <= 1'h1;
    s_regs;
    s_open;
    s_stuck;
    s_reject;
    s_sync;
    s_sbo;
    s_unint;
    end_of_test;
  end
endmodule

// ==== rtl/breaker_command_control.sv ====
// Breaker command control: command checks, timed pulses, status supervision
// What this block does
// RULE1: Accept local and remote commands, check them
// RULE2: Filter feedback, report open/closed state
// RULE3: Separate local and remote enables reject commands
// RULE4: Open and close gated by interlocks
// RULE5: Blocking input rejects commands and aborts them before the pulse starts
// RULE6: Control model: direct, enhanced, select-before-operate
// RULE7: Forced check overrides skip-check attribute
// RULE8: Enhanced models: status timeout gives invalid position
// RULE9: Pulse lasts configured duration
// RULE10: Confirmed switching ends pulse, minimum 100 ms
// RULE11: Intermediate timeout reports intermediate state
// RULE12: Close waits synchro time, then synchro switching
// RULE13: Synchro switch timeout resets without switching
// RULE14: Zero synchro switch time: never start
// RULE15: Selection lapses without timely operate
// RULE16: Outside logic merges trips and reclose close
// RULE17: 150 ms pulse on every breaker operation
// RULE18: Uncommanded status change flags unintended operation
// RULE19: Open needs open permit, close close permit
// RULE20: Both or neither feedback means intermediate
// RULE21: Count operations, events for commands and status
`timescale 1ns/1ns
module breaker_command_control #(
  parameter int COUNT_W = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic ms_tick,
  input wire logic [breaker_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [breaker_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [breaker_pkg::DATA_W-1:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic cmd_remote,
  input wire logic cmd_close,
  input wire logic cmd_select,
  input wire logic cmd_skip_check,
  input wire logic feedback_open,
  input wire logic feedback_closed,
  input wire logic open_permit,
  input wire logic close_permit,
  input wire logic command_block,
  input wire logic sync_state_ok,
  input wire logic sync_switch_impulse,
  input wire logic external_switching,
  output logic open_pulse_out,
  output logic close_pulse_out,
  output logic sync_switch_start,
  output logic operation_pulse,
  output logic unintended_operation,
  output logic breaker_opened,
  output logic breaker_closed,
  output logic breaker_intermediate,
  output logic invalid_position,
  output logic accept_event,
  output logic reject_event,
  output logic status_event
);
  localparam int DW = breaker_pkg::DATA_W;

  if (COUNT_W < 1 || COUNT_W > DW) begin : g_check
    $error("COUNT_W must be 1 to DATA_W");
  end

  typedef struct packed {
    breaker_pkg::cmd_state_e st;
    logic dir, remote, late, done;
    logic [DW-1:0] tmr, op_tmr, ctrl, t_oper, t_pulse, t_inter, t_synchk, t_synsw, t_sbo;
    logic opened, closed, inter;
    logic [DW-1:0] inter_t;
    logic known, last_closed, unint;
    logic [DW-1:0] oppl_t;
    logic [COUNT_W-1:0] count;
    logic start_sw, invalid, accept, reject, status_ev, open_out, close_out;
    logic [DW-1:0] rdata;
  } state_s;

  state_s q;
  state_s d;

  logic fb_valid, change, src_ok, chk, permit, allowed, enhanced;
  breaker_pkg::model_e model;

  always_comb begin
    d = q;
    d.accept = 1'b0;
    d.reject = 1'b0;
    d.invalid = 1'b0;
    d.status_ev = 1'b0;
    model = breaker_pkg::model_e'(q.ctrl[breaker_pkg::CTRL_MODEL_LSB +: 2]);
    enhanced = (model != breaker_pkg::model_direct_normal);
    // RULE20: exactly one feedback active is valid
    fb_valid = feedback_open ^ feedback_closed;
    change = fb_valid && q.known && (feedback_closed != q.last_closed);
    // RULE2: filtered state follows valid feedback
    if (fb_valid) begin
      d.opened = feedback_open;
      d.closed = feedback_closed;
      d.inter = 1'b0;
      d.inter_t = '0;
      d.known = 1'b1;
      d.last_closed = feedback_closed;
    end else begin
      // RULE11: intermediate after time limit
      if (q.inter_t >= q.t_inter) begin
        d.inter = 1'b1;
        d.opened = 1'b0;
        d.closed = 1'b0;
      end else if (ms_tick) begin
        d.inter_t = q.inter_t + 1'b1;
      end
    end
    if (ms_tick && q.oppl_t != '0) begin
      d.oppl_t = q.oppl_t - 1'b1;
    end
    if (change) begin
      // RULE21: count and report each change
      d.status_ev = 1'b1;
      d.count = q.count + 1'b1;
      // RULE17: operation pulse timer
      d.oppl_t = breaker_pkg::OPER_PULSE_MS;
      // RULE18: change without command or external
      if (q.st != breaker_pkg::st_pulse && q.st != breaker_pkg::st_wait_status
          && !external_switching) begin
        d.unint = 1'b1;
      end
    end
    // RULE3: per-source enable
    src_ok = cmd_remote ? q.ctrl[breaker_pkg::CTRL_REMOTE_BIT]
                        : q.ctrl[breaker_pkg::CTRL_LOCAL_BIT];
    // RULE7: forced check wins over skip attribute
    chk = q.ctrl[breaker_pkg::CTRL_FORCED_BIT] || !cmd_skip_check;
    // RULE4: interlock gating per direction
    // RULE19: permit must be active
    permit = cmd_close ? (close_permit || !chk) : (open_permit || !chk);
    // RULE1: all checks before forwarding
    allowed = src_ok && permit && !command_block;
    if (ms_tick) begin
      d.tmr = q.tmr + 1'b1;
      d.op_tmr = q.op_tmr + 1'b1;
    end
    unique case (q.st)
      breaker_pkg::st_idle: begin
        d.late = 1'b0;
        if (cmd_valid) begin
          // RULE6: model decides select phase
          if (!allowed || (model == breaker_pkg::model_sbo_enhanced) != cmd_select) begin
            d.reject = 1'b1;
          end else begin
            d.accept = 1'b1;
            // RULE18: new change wins over clear
            d.unint = change && !external_switching;
            d.dir = cmd_close;
            d.remote = cmd_remote;
            d.tmr = '0;
            d.op_tmr = '0;
            d.done = 1'b0;
            if (cmd_select) begin
              d.st = breaker_pkg::st_selected;
            end else if (cmd_close && chk && !sync_state_ok) begin
              d.st = breaker_pkg::st_sync_wait;
            end else begin
              d.st = breaker_pkg::st_pulse;
            end
          end
        end
      end
      breaker_pkg::st_selected: begin
        if (cmd_valid) begin
          if (!allowed || cmd_select || cmd_close != q.dir || cmd_remote != q.remote) begin
            d.reject = 1'b1;
            d.st = breaker_pkg::st_idle;
          end else begin
            d.accept = 1'b1;
            d.tmr = '0;
            d.op_tmr = '0;
            if (cmd_close && chk && !sync_state_ok) begin
              d.st = breaker_pkg::st_sync_wait;
            end else begin
              d.st = breaker_pkg::st_pulse;
            end
          end
        // RULE15: selection lapses
        end else if (q.tmr >= q.t_sbo || command_block) begin
          d.reject = 1'b1;
          d.st = breaker_pkg::st_idle;
        end
      end
      breaker_pkg::st_sync_wait: begin
        // RULE5: blocking aborts pending command
        if (command_block) begin
          d.reject = 1'b1;
          d.st = breaker_pkg::st_idle;
        end else if (sync_state_ok) begin
          d.tmr = '0;
          d.op_tmr = '0;
          d.st = breaker_pkg::st_pulse;
        // RULE12: synchro wait expiry
        end else if (q.tmr >= q.t_synchk) begin
          d.tmr = '0;
          // RULE14: zero time never starts switching
          if (q.t_synsw == '0) begin
            d.reject = 1'b1;
            d.st = breaker_pkg::st_idle;
          end else begin
            d.start_sw = 1'b1;
            d.st = breaker_pkg::st_synsw_wait;
          end
        end
      end
      breaker_pkg::st_synsw_wait: begin
        if (command_block) begin
          d.start_sw = 1'b0;
          d.reject = 1'b1;
          d.st = breaker_pkg::st_idle;
        end else if (sync_switch_impulse) begin
          d.start_sw = 1'b0;
          d.tmr = '0;
          d.op_tmr = '0;
          d.st = breaker_pkg::st_pulse;
        // RULE13: synchro switch expiry resets
        end else if (q.tmr >= q.t_synsw) begin
          d.start_sw = 1'b0;
          d.reject = 1'b1;
          d.st = breaker_pkg::st_idle;
        end
      end
      breaker_pkg::st_pulse: begin
        if (change && feedback_closed == q.dir) begin
          d.done = 1'b1;
        end
        // RULE8: late status reported once
        if (enhanced && !q.done && !q.late && q.op_tmr >= q.t_oper) begin
          d.invalid = 1'b1;
          d.late = 1'b1;
        end
        // RULE10: early end after minimum
        if (q.done && q.tmr >= breaker_pkg::MIN_PULSE_MS) begin
          d.st = breaker_pkg::st_idle;
        // RULE9: full pulse duration
        end else if (q.tmr >= q.t_pulse) begin
          d.st = (enhanced && !q.done && !d.late) ? breaker_pkg::st_wait_status
                                                  : breaker_pkg::st_idle;
        end
      end
      breaker_pkg::st_wait_status: begin
        if (change && feedback_closed == q.dir) begin
          d.st = breaker_pkg::st_idle;
        // RULE8: timeout reports invalid position
        end else if (q.op_tmr >= q.t_oper) begin
          d.invalid = 1'b1;
          d.st = breaker_pkg::st_idle;
        end
      end
      default: begin
        d.st = breaker_pkg::st_idle;
      end
    endcase
    // Register writes
    if (reg_write) begin
      unique case (reg_addr)
        breaker_pkg::REG_CTRL: d.ctrl = reg_wdata & 16'h001f;
        breaker_pkg::REG_OPER_TIME: d.t_oper = reg_wdata;
        breaker_pkg::REG_PULSE_TIME: d.t_pulse = reg_wdata;
        breaker_pkg::REG_INTER_TIME: d.t_inter = reg_wdata;
        breaker_pkg::REG_SYNCHK_TIME: d.t_synchk = reg_wdata;
        breaker_pkg::REG_SYNSW_TIME: d.t_synsw = reg_wdata;
        breaker_pkg::REG_SBO_TIME: d.t_sbo = reg_wdata;
        default: d.ctrl = d.ctrl;
      endcase
      if (reg_addr == breaker_pkg::REG_CTRL && reg_wdata[breaker_pkg::CTRL_COUNT_CLR_BIT]
          && !change) begin
        d.count = '0;
      end
    end
    // Register reads, data next cycle
    d.rdata = '0;
    if (reg_read) begin
      unique case (reg_addr)
        breaker_pkg::REG_CTRL: d.rdata = q.ctrl;
        breaker_pkg::REG_OPER_TIME: d.rdata = q.t_oper;
        breaker_pkg::REG_PULSE_TIME: d.rdata = q.t_pulse;
        breaker_pkg::REG_INTER_TIME: d.rdata = q.t_inter;
        breaker_pkg::REG_SYNCHK_TIME: d.rdata = q.t_synchk;
        breaker_pkg::REG_SYNSW_TIME: d.rdata = q.t_synsw;
        breaker_pkg::REG_SBO_TIME: d.rdata = q.t_sbo;
        breaker_pkg::REG_STATUS: begin
          d.rdata[breaker_pkg::STAT_OPENED_BIT] = q.opened;
          d.rdata[breaker_pkg::STAT_CLOSED_BIT] = q.closed;
          d.rdata[breaker_pkg::STAT_INTER_BIT] = q.inter;
          d.rdata[breaker_pkg::STAT_UNINT_BIT] = q.unint;
          d.rdata[breaker_pkg::STAT_SYNSW_BIT] = q.start_sw;
          d.rdata[breaker_pkg::STAT_BUSY_BIT] = (q.st != breaker_pkg::st_idle);
          d.rdata[breaker_pkg::STAT_SELECTED_BIT] = (q.st == breaker_pkg::st_selected);
        end
        breaker_pkg::REG_OP_COUNT: d.rdata[COUNT_W-1:0] = q.count;
        default: d.rdata = '0;
      endcase
    end
    // Pulse outputs from next state
    d.open_out = (d.st == breaker_pkg::st_pulse) && !d.dir;
    d.close_out = (d.st == breaker_pkg::st_pulse) && d.dir;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      q <= '0;
      q.ctrl <= breaker_pkg::CTRL_RESET;
      q.t_oper <= breaker_pkg::OPER_TIME_RESET;
      q.t_pulse <= breaker_pkg::PULSE_TIME_RESET;
      q.t_inter <= breaker_pkg::INTER_TIME_RESET;
      q.t_synchk <= breaker_pkg::SYNCHK_TIME_RESET;
      q.t_synsw <= breaker_pkg::SYNSW_TIME_RESET;
      q.t_sbo <= breaker_pkg::SBO_TIME_RESET;
    end else begin
      q <= d;
    end
  end

  assign reg_rdata = q.rdata;
  assign open_pulse_out = q.open_out;
  assign close_pulse_out = q.close_out;
  assign sync_switch_start = q.start_sw;
  assign operation_pulse = (q.oppl_t != '0);
  assign unintended_operation = q.unint;
  assign breaker_opened = q.opened;
  assign breaker_closed = q.closed;
  assign breaker_intermediate = q.inter;
  assign invalid_position = q.invalid;
  assign accept_event = q.accept;
  assign reject_event = q.reject;
  assign status_event = q.status_ev;
endmodule

// ==== rtl/breaker_pkg.sv ====
// Constants and types for the breaker command control block
package breaker_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // Register indices
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_OPER_TIME = 4'h1;
  localparam logic [3:0] REG_PULSE_TIME = 4'h2;
  localparam logic [3:0] REG_INTER_TIME = 4'h3;
  localparam logic [3:0] REG_SYNCHK_TIME = 4'h4;
  localparam logic [3:0] REG_SYNSW_TIME = 4'h5;
  localparam logic [3:0] REG_SBO_TIME = 4'h6;
  localparam logic [3:0] REG_STATUS = 4'h7;
  localparam logic [3:0] REG_OP_COUNT = 4'h8;
  // Control field positions
  localparam int CTRL_LOCAL_BIT = 0;
  localparam int CTRL_REMOTE_BIT = 1;
  localparam int CTRL_MODEL_LSB = 2;
  localparam int CTRL_FORCED_BIT = 4;
  localparam int CTRL_COUNT_CLR_BIT = 5;
  // Status field positions
  localparam int STAT_OPENED_BIT = 0;
  localparam int STAT_CLOSED_BIT = 1;
  localparam int STAT_INTER_BIT = 2;
  localparam int STAT_UNINT_BIT = 3;
  localparam int STAT_SYNSW_BIT = 4;
  localparam int STAT_BUSY_BIT = 5;
  localparam int STAT_SELECTED_BIT = 6;
  // Reset values
  localparam logic [15:0] CTRL_RESET = 16'h0013;
  localparam logic [15:0] OPER_TIME_RESET = 16'h00c8;
  localparam logic [15:0] PULSE_TIME_RESET = 16'h012c;
  localparam logic [15:0] INTER_TIME_RESET = 16'h0064;
  localparam logic [15:0] SYNCHK_TIME_RESET = 16'h03e8;
  localparam logic [15:0] SYNSW_TIME_RESET = 16'h0000;
  localparam logic [15:0] SBO_TIME_RESET = 16'h1388;
  // Fixed times in milliseconds
  localparam logic [15:0] MIN_PULSE_MS = 16'h0064;
  localparam logic [15:0] OPER_PULSE_MS = 16'h0096;
  typedef enum logic [1:0] {
    model_direct_normal,
    model_direct_enhanced,
    model_sbo_enhanced
  } model_e;
  typedef enum logic [2:0] {
    st_idle,
    st_selected,
    st_sync_wait,
    st_synsw_wait,
    st_pulse,
    st_wait_status
  } cmd_state_e;
endpackage
